// file: hdl/cdt_decoder.sv
`timescale 1ns/1ps
// Behaviour
// - 75: immediate to direct, 3 bytes, 2 cycles
// - F6-F7: accumulator to indirect, 1 byte, 1 cycle
// - A6-A7: direct to indirect, 2 bytes, 2 cycles
// - 76-77: immediate to indirect, 2 bytes, 1 cycle
// - 90: load data pointer, 3 bytes, 2 cycles
// - 93/94: program byte reads, 1 byte, 2 cycles
// - E2-E3 read, F2-F3 write, 8-bit external
// - E0 read, F0 write, 16-bit external
// - C0 push, D0 pop, 2 bytes, 2 cycles
// - exchanges C8-CF, C5, C6-C7 take one cycle
// - D6-D7 low nibble exchange, one cycle
// - 82 and B0 carry AND, 2 bytes, 2 cycles
// - 72 and A0 carry OR, 2 bytes, 2 cycles
// - A2 bit to carry 1 cycle; 92 two
// - 12 far call, 3 bytes, 2 cycles
// - 80 relative branch, 2 bytes, 2 cycles
// - 20 bit set, 30 bit clear, 3 bytes
// - 10 branch on bit and clear it
// - 73 jump accumulator plus data pointer
// - 60 zero, 70 non-zero, 2 bytes
// - compare forms B4-B7, B8-BF, 3 bytes
// - D8-DF two bytes, D5 three, two cycles
module cdt_decoder
	import cdt_pkg::*;
(
	core_clk,
	rst,
	opcode_in,
	opcode_valid,
	addr_low,
	pc_next,
	dec_out,
	pc_out,
	dec_valid
);
	input wire logic core_clk; // core clock, 100 MHz
	input wire logic rst; // asynchronous reset, active high
	input wire logic [7:0] opcode_in; // fetched opcode byte
	input wire logic opcode_valid; // opcode byte is present
	input wire logic [7:0] addr_low; // second instruction byte for page forms
	input wire logic [15:0] pc_next; // program counter after this instruction
	output cdt_dec_t dec_out; // registered decode result
	output cdt_pc_t pc_out; // registered program counter control
	output logic dec_valid; // decode result is new this cycle

	cdt_dec_t dec_r; // registered decode
	cdt_dec_t dec_nxt; // next decode
	cdt_pc_t pc_r; // registered pc control
	cdt_pc_t pc_nxt; // next pc control
	logic valid_r; // registered valid
	logic valid_nxt; // next valid
	logic pg_call; // page call form seen
	logic pg_jump; // page jump form seen
	logic [15:0] pg_target; // page form target

	// page target former
	// page forms are told apart by the low five opcode bits
	cdt_page_target u_page (
		.opcode(opcode_in),
		.addr_low(addr_low),
		.pc_next(pc_next),
		.is_page_call(pg_call),
		.is_page_jump(pg_jump),
		.target(pg_target)
	);

	// decode table: masked ranges first, then single opcodes
	// no masked range overlaps a single code, so the order is free
	// every path leaves length, cycles and class assigned
	// unknown opcodes fall to known = 0 with one byte, one cycle
	always_comb begin
		// defaults: one byte, one cycle, recognised opcode
		dec_nxt = '0;
		dec_nxt.opcode = opcode_in;
		dec_nxt.iclass = CDT_NONE;
		dec_nxt.src = CDT_SRC_NONE;
		dec_nxt.length = LEN_1;
		dec_nxt.cycles = CYC_1;
		dec_nxt.ptr_sel = opcode_in[0];
		dec_nxt.reg_sel = opcode_in[2:0];
		dec_nxt.known = 1'b1;
		// program counter control idle unless a branch form sets it
		pc_nxt = '0;
		// valid only rides along one cycle behind the opcode
		valid_nxt = opcode_valid;

		// paired and octet ranges first
		// pair masks drop bit0, octet masks drop the low three bits
		if ((opcode_in & MASK_PAIR) == OP_MOV_IND_A) begin
			// accumulator stored through the pointer register
			dec_nxt.iclass = CDT_MOV_IND_A;
			dec_nxt.src = CDT_SRC_ACC;
		end else if ((opcode_in & MASK_PAIR) == OP_MOV_IND_DIR) begin
			// direct byte copied through the pointer register
			dec_nxt.iclass = CDT_MOV_IND_DIR;
			dec_nxt.src = CDT_SRC_DIR;
			dec_nxt.length = LEN_2;
			dec_nxt.cycles = CYC_2;
		end else if ((opcode_in & MASK_PAIR) == OP_MOV_IND_IMM) begin
			// immediate stored through the pointer register
			dec_nxt.iclass = CDT_MOV_IND_IMM;
			dec_nxt.src = CDT_SRC_IMM;
			dec_nxt.length = LEN_2;
		end else if ((opcode_in & MASK_PAIR) == OP_XRD_IND) begin
			// external read, 8-bit address from the pointer
			dec_nxt.iclass = CDT_EXT_READ;
			dec_nxt.src = CDT_SRC_IND;
			dec_nxt.cycles = CYC_2;
		end else if ((opcode_in & MASK_PAIR) == OP_XWR_IND) begin
			// external write, 8-bit address from the pointer
			dec_nxt.iclass = CDT_EXT_WRITE;
			dec_nxt.src = CDT_SRC_IND;
			dec_nxt.cycles = CYC_2;
		end else if ((opcode_in & MASK_OCTET) == OP_XCH_REG) begin
			// accumulator swapped with a bank register
			dec_nxt.iclass = CDT_XCH;
			dec_nxt.src = CDT_SRC_REG;
		end else if ((opcode_in & MASK_PAIR) == OP_XCH_IND) begin
			// accumulator swapped with pointed memory
			// bit0 selects the pointer register
			dec_nxt.iclass = CDT_XCH;
			dec_nxt.src = CDT_SRC_IND;
		end else if ((opcode_in & MASK_PAIR) == OP_NIB_XCH) begin
			// low nibbles only swapped with pointed memory
			dec_nxt.iclass = CDT_NIB_XCH;
			dec_nxt.src = CDT_SRC_IND;
		end else if ((opcode_in & MASK_OCTET) == OP_CBU_REG) begin
			// bank register compared against an immediate
			// third byte holds the relative offset
			dec_nxt.iclass = CDT_CBU;
			dec_nxt.src = CDT_SRC_REG;
			dec_nxt.length = LEN_3;
			dec_nxt.cycles = CYC_2;
			pc_nxt.rel_form = 1'b1;
		end else if ((opcode_in & MASK_PAIR) == OP_CBU_IND) begin
			// pointed memory compared against an immediate
			dec_nxt.iclass = CDT_CBU;
			dec_nxt.src = CDT_SRC_IND;
			dec_nxt.length = LEN_3;
			dec_nxt.cycles = CYC_2;
			pc_nxt.rel_form = 1'b1;
		end else if ((opcode_in & MASK_OCTET) == OP_DBN_REG) begin
			// bank register decremented, offset in second byte
			// low three bits select the bank register
			dec_nxt.iclass = CDT_DBN;
			dec_nxt.src = CDT_SRC_REG;
			dec_nxt.length = LEN_2;
			dec_nxt.cycles = CYC_2;
			pc_nxt.rel_form = 1'b1;
		end else if (pg_call || pg_jump) begin
			// page forms, target built by the page former
			// only reached when no masked range claimed the opcode
			dec_nxt.iclass = pg_call ? CDT_CALL : CDT_JUMP;
			dec_nxt.length = LEN_2;
			dec_nxt.cycles = CYC_2;
			pc_nxt.page_form = 1'b1;
			pc_nxt.page_target = pg_target;
		end else begin
			// single opcodes
			// full eight-bit match, anything else is outside this part
			unique case (opcode_in)
				// data transfer
				OP_MOV_DIR_IMM: begin
					// immediate into a direct byte
					dec_nxt.iclass = CDT_MOV_DIR_IMM;
					dec_nxt.src = CDT_SRC_IMM;
					dec_nxt.length = LEN_3;
					dec_nxt.cycles = CYC_2;
				end
				OP_MOV_DP_IMM: begin
					// both pointer bytes follow the opcode
					dec_nxt.iclass = CDT_MOV_DP_IMM;
					dec_nxt.src = CDT_SRC_IMM;
					dec_nxt.length = LEN_3;
					dec_nxt.cycles = CYC_2;
				end
				OP_PRG_READ_DP, OP_PRG_READ_PC: begin
					// program byte read, base picked by opcode
					dec_nxt.iclass = CDT_PRG_READ;
					dec_nxt.src = (opcode_in == OP_PRG_READ_DP) ? CDT_SRC_DP : CDT_SRC_PC;
					dec_nxt.cycles = CYC_2;
				end
				OP_XRD_DP, OP_XWR_DP: begin
					// external access, 16-bit address from the pointer
					// ext_wide marks the 16-bit address form
					dec_nxt.iclass = (opcode_in == OP_XRD_DP) ? CDT_EXT_READ : CDT_EXT_WRITE;
					dec_nxt.src = CDT_SRC_DP;
					dec_nxt.ext_wide = 1'b1;
					dec_nxt.cycles = CYC_2;
				end
				OP_PUSH, OP_POP: begin
					// stack access with a direct operand
					dec_nxt.iclass = (opcode_in == OP_PUSH) ? CDT_PUSH : CDT_POP;
					dec_nxt.src = CDT_SRC_DIR;
					dec_nxt.length = LEN_2;
					dec_nxt.cycles = CYC_2;
				end
				OP_XCH_DIR: begin
					// accumulator swapped with a direct byte
					dec_nxt.iclass = CDT_XCH;
					dec_nxt.src = CDT_SRC_DIR;
					dec_nxt.length = LEN_2;
				end

				// boolean
				OP_CLR_C, OP_SET_C, OP_CPL_C: begin
					// carry alone, no operand byte
					dec_nxt.iclass = CDT_BIT_SET_CLR; // carry only
				end
				OP_CLR_BIT, OP_SET_BIT, OP_CPL_BIT: begin
					// direct bit operand in the second byte
					dec_nxt.iclass = CDT_BIT_SET_CLR; // direct bit
					dec_nxt.src = CDT_SRC_DIR;
					dec_nxt.length = LEN_2;
				end
				OP_ANL_C_BIT, OP_ANL_C_NBIT, OP_ORL_C_BIT, OP_ORL_C_NBIT: begin
					// invert picks the inverted bit, cond_sense picks or
					// all four take two bytes and two cycles
					dec_nxt.iclass = CDT_BIT_LOGIC;
					dec_nxt.src = CDT_SRC_DIR;
					dec_nxt.invert = (opcode_in == OP_ANL_C_NBIT) || (opcode_in == OP_ORL_C_NBIT);
					dec_nxt.cond_sense = (opcode_in == OP_ORL_C_BIT) || (opcode_in == OP_ORL_C_NBIT);
					dec_nxt.length = LEN_2;
					dec_nxt.cycles = CYC_2;
				end
				OP_MOV_C_BIT: begin
					// direct bit into carry
					dec_nxt.iclass = CDT_BIT_MOVE;
					dec_nxt.src = CDT_SRC_DIR;
					dec_nxt.length = LEN_2;
				end
				OP_MOV_BIT_C: begin
					// carry into direct bit, read-modify-write
					dec_nxt.iclass = CDT_BIT_MOVE;
					dec_nxt.src = CDT_SRC_NONE;
					dec_nxt.length = LEN_2;
					dec_nxt.cycles = CYC_2;
				end

				// branching
				OP_FAR_CALL, OP_FAR_JUMP: begin
					// both target bytes follow the opcode
					dec_nxt.iclass = (opcode_in == OP_FAR_CALL) ? CDT_CALL : CDT_JUMP;
					dec_nxt.length = LEN_3;
					dec_nxt.cycles = CYC_2;
					pc_nxt.far_form = 1'b1;
				end
				OP_RET, OP_RETI: begin
					// return address comes off the stack
					// both return forms share one class
					dec_nxt.iclass = CDT_RETURN; // stack pop of pc
					dec_nxt.cycles = CYC_2;
				end
				OP_REL_BRANCH: begin
					// signed offset in the second byte
					dec_nxt.iclass = CDT_JUMP;
					dec_nxt.length = LEN_2;
					dec_nxt.cycles = CYC_2;
					pc_nxt.rel_form = 1'b1;
				end
				OP_JC, OP_JNC, OP_JZ, OP_JNZ: begin
					// carry or accumulator tested, offset second byte
					// cond_sense set for carry set and accumulator non-zero
					dec_nxt.iclass = CDT_COND_BRANCH;
					dec_nxt.src = (opcode_in == OP_JZ || opcode_in == OP_JNZ) ? CDT_SRC_ACC : CDT_SRC_NONE;
					dec_nxt.cond_sense = (opcode_in == OP_JC) || (opcode_in == OP_JNZ);
					dec_nxt.length = LEN_2;
					dec_nxt.cycles = CYC_2;
					pc_nxt.rel_form = 1'b1;
				end
				OP_JB, OP_JNB: begin
					// direct bit tested, offset in the third byte
					dec_nxt.iclass = CDT_COND_BRANCH;
					dec_nxt.src = CDT_SRC_DIR;
					dec_nxt.cond_sense = (opcode_in == OP_JB);
					dec_nxt.length = LEN_3;
					dec_nxt.cycles = CYC_2;
					pc_nxt.rel_form = 1'b1;
				end
				OP_BTC_BRANCH: begin
					// bit tested and cleared when the branch is taken
					// cond_sense fixed, the bit must be one
					dec_nxt.iclass = CDT_BTC_BRANCH;
					dec_nxt.src = CDT_SRC_DIR;
					dec_nxt.cond_sense = 1'b1;
					dec_nxt.length = LEN_3;
					dec_nxt.cycles = CYC_2;
					pc_nxt.rel_form = 1'b1;
				end
				OP_JMP_A_DP: begin
					// target is accumulator plus the data pointer
					dec_nxt.iclass = CDT_JUMP;
					dec_nxt.src = CDT_SRC_DP;
					dec_nxt.cycles = CYC_2;
					pc_nxt.acc_dp_form = 1'b1;
				end
				OP_CBU_A_DIR, OP_CBU_A_IMM: begin
					// accumulator compared, offset in the third byte
					// direct and immediate forms differ only in source
					dec_nxt.iclass = CDT_CBU;
					dec_nxt.src = (opcode_in == OP_CBU_A_DIR) ? CDT_SRC_DIR : CDT_SRC_IMM;
					dec_nxt.length = LEN_3;
					dec_nxt.cycles = CYC_2;
					pc_nxt.rel_form = 1'b1;
				end
				OP_DBN_DIR: begin
					// direct byte decremented, offset in the third byte
					dec_nxt.iclass = CDT_DBN;
					dec_nxt.src = CDT_SRC_DIR;
					dec_nxt.length = LEN_3;
					dec_nxt.cycles = CYC_2;
					pc_nxt.rel_form = 1'b1;
				end
				OP_NOP: begin
					// one byte, one cycle, nothing touched
					dec_nxt.iclass = CDT_NONE; // no operation
				end
				default: begin
					// opcode outside this decoder's part
					dec_nxt.known = 1'b0;
				end
			endcase
		end
	end

	// register the decode
	// no clock enable: every edge takes a fresh decode
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			// outputs idle: class none, nothing valid
			dec_r <= '0;
			pc_r <= '0;
			valid_r <= 1'b0;
		end else begin
			// new decode of whatever opcode stands this edge
			dec_r <= dec_nxt;
			pc_r <= pc_nxt;
			valid_r <= valid_nxt;
		end
	end

	// outputs straight from flip-flops
	assign dec_out = dec_r;
	assign pc_out = pc_r;
	assign dec_valid = valid_r;
endmodule : cdt_decoder

// file: hdl/cdt_pkg.sv
package cdt_pkg;
	// opcode values decoded by this block
	localparam logic [7:0] OP_MOV_DIR_IMM = 8'h75;
	localparam logic [7:0] OP_MOV_IND_A = 8'hF6;
	localparam logic [7:0] OP_MOV_IND_DIR = 8'hA6;
	localparam logic [7:0] OP_MOV_IND_IMM = 8'h76;
	localparam logic [7:0] OP_MOV_DP_IMM = 8'h90;
	localparam logic [7:0] OP_PRG_READ_DP = 8'h93;
	localparam logic [7:0] OP_PRG_READ_PC = 8'h94;
	localparam logic [7:0] OP_XRD_IND = 8'hE2;
	localparam logic [7:0] OP_XWR_IND = 8'hF2;
	localparam logic [7:0] OP_XRD_DP = 8'hE0;
	localparam logic [7:0] OP_XWR_DP = 8'hF0;
	localparam logic [7:0] OP_PUSH = 8'hC0;
	localparam logic [7:0] OP_POP = 8'hD0;
	localparam logic [7:0] OP_XCH_REG = 8'hC8;
	localparam logic [7:0] OP_XCH_DIR = 8'hC5;
	localparam logic [7:0] OP_XCH_IND = 8'hC6;
	localparam logic [7:0] OP_NIB_XCH = 8'hD6;
	localparam logic [7:0] OP_CLR_C = 8'hC3;
	localparam logic [7:0] OP_CLR_BIT = 8'hC2;
	localparam logic [7:0] OP_SET_C = 8'hD3;
	localparam logic [7:0] OP_SET_BIT = 8'hD2;
	localparam logic [7:0] OP_CPL_C = 8'hB3;
	localparam logic [7:0] OP_CPL_BIT = 8'hB2;
	localparam logic [7:0] OP_ANL_C_BIT = 8'h82;
	localparam logic [7:0] OP_ANL_C_NBIT = 8'hB0;
	localparam logic [7:0] OP_ORL_C_BIT = 8'h72;
	localparam logic [7:0] OP_ORL_C_NBIT = 8'hA0;
	localparam logic [7:0] OP_MOV_C_BIT = 8'hA2;
	localparam logic [7:0] OP_MOV_BIT_C = 8'h92;
	localparam logic [7:0] OP_FAR_CALL = 8'h12;
	localparam logic [7:0] OP_FAR_JUMP = 8'h02;
	localparam logic [7:0] OP_RET = 8'h22;
	localparam logic [7:0] OP_RETI = 8'h32;
	localparam logic [7:0] OP_REL_BRANCH = 8'h80;
	localparam logic [7:0] OP_JC = 8'h40;
	localparam logic [7:0] OP_JNC = 8'h50;
	localparam logic [7:0] OP_JB = 8'h20;
	localparam logic [7:0] OP_JNB = 8'h30;
	localparam logic [7:0] OP_BTC_BRANCH = 8'h10;
	localparam logic [7:0] OP_JMP_A_DP = 8'h73;
	localparam logic [7:0] OP_JZ = 8'h60;
	localparam logic [7:0] OP_JNZ = 8'h70;
	localparam logic [7:0] OP_CBU_A_DIR = 8'hB5;
	localparam logic [7:0] OP_CBU_A_IMM = 8'hB4;
	localparam logic [7:0] OP_CBU_REG = 8'hB8;
	localparam logic [7:0] OP_CBU_IND = 8'hB6;
	localparam logic [7:0] OP_DBN_REG = 8'hD8;
	localparam logic [7:0] OP_DBN_DIR = 8'hD5;
	localparam logic [7:0] OP_NOP = 8'h00;
	// page call / page jump low five bits
	localparam logic [4:0] PAGE_CALL_LOW = 5'h11;
	localparam logic [4:0] PAGE_JUMP_LOW = 5'h01;
	// masks for opcode ranges
	localparam logic [7:0] MASK_PAIR = 8'hFE;
	localparam logic [7:0] MASK_OCTET = 8'hF8;
	// lengths and machine-cycle counts
	localparam logic [1:0] LEN_1 = 2'h1;
	localparam logic [1:0] LEN_2 = 2'h2;
	localparam logic [1:0] LEN_3 = 2'h3;
	localparam logic [2:0] CYC_1 = 3'h1;
	localparam logic [2:0] CYC_2 = 3'h2;
	// output reset value
	localparam logic [7:0] OPCODE_RST = 8'h00;

	// instruction class seen by the datapath
	typedef enum logic [4:0] {
		CDT_NONE, CDT_MOV_DIR_IMM, CDT_MOV_IND_A, CDT_MOV_IND_DIR, CDT_MOV_IND_IMM,
		CDT_MOV_DP_IMM, CDT_PRG_READ, CDT_EXT_READ, CDT_EXT_WRITE, CDT_PUSH, CDT_POP,
		CDT_XCH, CDT_NIB_XCH, CDT_BIT_SET_CLR, CDT_BIT_LOGIC, CDT_BIT_MOVE,
		CDT_CALL, CDT_JUMP, CDT_RETURN, CDT_COND_BRANCH, CDT_BTC_BRANCH,
		CDT_CBU, CDT_DBN
	} cdt_class_t;

	// operand source for memory / branch forms
	typedef enum logic [2:0] {
		CDT_SRC_NONE, CDT_SRC_ACC, CDT_SRC_DIR, CDT_SRC_IMM, CDT_SRC_IND, CDT_SRC_REG,
		CDT_SRC_DP, CDT_SRC_PC
	} cdt_src_t;

	// decoded instruction bundle
	typedef struct packed {
		logic [7:0] opcode;
		cdt_class_t iclass;
		cdt_src_t src;
		logic [1:0] length;
		logic [2:0] cycles;
		logic ptr_sel;
		logic [2:0] reg_sel;
		logic invert;
		logic cond_sense;
		logic ext_wide;
		logic known;
	} cdt_dec_t;

	// branch target control for the program counter
	typedef struct packed {
		logic page_form;
		logic [15:0] page_target;
		logic far_form;
		logic rel_form;
		logic acc_dp_form;
	} cdt_pc_t;
endpackage : cdt_pkg

// file: hdl/cdt_page_target.sv
`timescale 1ns/1ps
// page call / page jump target forming
module cdt_page_target
	import cdt_pkg::*;
(
	input wire logic [7:0] opcode,
	input wire logic [7:0] addr_low,
	input wire logic [15:0] pc_next,
	output logic is_page_call,
	output logic is_page_jump,
	output logic [15:0] target
);
	// low five bits identify the form
	always_comb begin
		is_page_call = (opcode[4:0] == PAGE_CALL_LOW);
		is_page_jump = (opcode[4:0] == PAGE_JUMP_LOW);
		// upper pc bits kept, three opcode bits give a10..a8
		target = {pc_next[15:11], opcode[7:5], addr_low};
	end
endmodule : cdt_page_target

// file: dv/cdt_props.sv
`timescale 1ns/1ps
// checker watching the decoder ports
module cdt_props
	import cdt_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [7:0] opcode_in,
	input wire logic opcode_valid,
	input wire logic [7:0] addr_low,
	input wire logic [15:0] pc_next,
	input wire cdt_dec_t dec_out,
	input wire cdt_pc_t pc_out,
	input wire logic dec_valid
);
	// single domain, reset disables every check
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	a_store_imm_len: assert property (opcode_in == OP_MOV_DIR_IMM |=> dec_out.length == LEN_3 && dec_out.cycles == CYC_2)
		else $error("store immediate length or cycles wrong");
	a_ind_acc_ptr: assert property (opcode_in[7:1] == 7'h7B |=> dec_out.cycles == CYC_1 && dec_out.ptr_sel == $past(opcode_in[0]))
		else $error("accumulator to indirect decode wrong");
	a_ext_two_cyc: assert property (opcode_in inside {8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3} |=> dec_out.cycles == CYC_2 && dec_out.length == LEN_1)
		else $error("external access timing wrong");
	a_xch_one_cyc: assert property (opcode_in[7:3] == 5'h19 || opcode_in inside {8'hC5, 8'hC6, 8'hC7} |=> dec_out.cycles == CYC_1)
		else $error("exchange not one cycle");
	a_cbu_three_len: assert property (opcode_in[7:4] == 4'hB && opcode_in[3:2] != 2'h0 |=> dec_out.length == LEN_3 && dec_out.cycles == CYC_2)
		else $error("compare branch length wrong");
	a_dbn_reg_sel: assert property (opcode_in[7:3] == 5'h1B |=> dec_out.length == LEN_2 && dec_out.reg_sel == $past(opcode_in[2:0]))
		else $error("decrement branch register decode wrong");
	a_far_call_form: assert property (opcode_in == OP_FAR_CALL |=> pc_out.far_form && dec_out.length == LEN_3 && dec_out.cycles == CYC_2)
		else $error("far call decode wrong");
	a_page_target: assert property (opcode_in[4:0] == PAGE_CALL_LOW |=> pc_out.page_form && pc_out.page_target == {$past(pc_next[15:11]), $past(opcode_in[7:5]), $past(addr_low)})
		else $error("page call target wrong");
	a_valid_follow: assert property (1'b1 |=> dec_valid == $past(opcode_valid))
		else $error("valid flag not one cycle behind");

	// main scenarios reached
	cover property (opcode_in[4:0] == PAGE_CALL_LOW ##1 pc_out.page_form);
	cover property (opcode_in == OP_FAR_CALL ##1 pc_out.far_form);
	cover property (opcode_valid ##1 dec_valid);
endmodule : cdt_props

bind cdt_decoder cdt_props props_u (.core_clk(core_clk), .rst(rst), .opcode_in(opcode_in), .opcode_valid(opcode_valid),
	.addr_low(addr_low), .pc_next(pc_next), .dec_out(dec_out), .pc_out(pc_out), .dec_valid(dec_valid));

// file: dv/tb_top.sv
`timescale 1ns/1ps
// compare two values, count and report a difference
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin num_errors++; $display("mismatch t=%0t got %0h exp %0h", $time, a, b); end end
// decoder testbench
module tb_top
	import cdt_pkg::*;
;
	logic core_clk = 1'b0; // core clock
	logic rst = 1'b1; // reset held at start
	logic [7:0] opcode_in; // opcode stimulus
	logic opcode_valid; // opcode present flag
	logic [7:0] addr_low; // second byte for page forms
	logic [15:0] pc_next; // pc after instruction
	cdt_dec_t dec_out; // decode result
	cdt_pc_t pc_out; // pc control
	logic dec_valid; // result valid
	int num_errors; // mismatches seen
	int comparisons; // compares made

	// 100 MHz clock
	always #5 core_clk = ~core_clk;

	cdt_decoder dut_u (.core_clk(core_clk), .rst(rst), .opcode_in(opcode_in), .opcode_valid(opcode_valid),
		.addr_low(addr_low), .pc_next(pc_next), .dec_out(dec_out), .pc_out(pc_out), .dec_valid(dec_valid));

	// drive one opcode at a falling edge, judge it one cycle later
	task check_op(input logic [7:0] op, input logic [1:0] len, input logic [2:0] cyc, input cdt_class_t cls);
		opcode_in = op;
		opcode_valid = 1'b1;
		@(negedge core_clk);
		`CHK(dec_out.opcode, op)
		`CHK(dec_out.known, 1'b1)
		`CHK(dec_out.length, len)
		`CHK(dec_out.cycles, cyc)
		`CHK(dec_valid, 1'b1)
		if (cls != CDT_NONE) `CHK(dec_out.iclass, cls)
	endtask : check_op

	// data moves into direct, indirect and pointer places
	task t_moves;
		check_op(8'h75, 2'h3, 3'h2, CDT_MOV_DIR_IMM);
		check_op(8'hF6, 2'h1, 3'h1, CDT_MOV_IND_A);
		check_op(8'hF7, 2'h1, 3'h1, CDT_MOV_IND_A);
		`CHK(dec_out.ptr_sel, 1'b1)
		check_op(8'hA6, 2'h2, 3'h2, CDT_MOV_IND_DIR);
		check_op(8'hA7, 2'h2, 3'h2, CDT_MOV_IND_DIR);
		check_op(8'h76, 2'h2, 3'h1, CDT_MOV_IND_IMM);
		check_op(8'h77, 2'h2, 3'h1, CDT_MOV_IND_IMM);
		check_op(8'h90, 2'h3, 3'h2, CDT_MOV_DP_IMM);
		check_op(8'h93, 2'h1, 3'h2, CDT_PRG_READ);
		`CHK(dec_out.src, CDT_SRC_DP)
		check_op(8'h94, 2'h1, 3'h2, CDT_PRG_READ);
		`CHK(dec_out.src, CDT_SRC_PC)
	endtask : t_moves

	// external data, stack
	task t_ext;
		check_op(8'hE2, 2'h1, 3'h2, CDT_EXT_READ);
		`CHK(dec_out.ext_wide, 1'b0)
		check_op(8'hE3, 2'h1, 3'h2, CDT_EXT_READ);
		check_op(8'hF2, 2'h1, 3'h2, CDT_EXT_WRITE);
		check_op(8'hF3, 2'h1, 3'h2, CDT_EXT_WRITE);
		check_op(8'hE0, 2'h1, 3'h2, CDT_EXT_READ);
		`CHK(dec_out.ext_wide, 1'b1)
		check_op(8'hF0, 2'h1, 3'h2, CDT_EXT_WRITE);
		check_op(8'hC0, 2'h2, 3'h2, CDT_PUSH);
		check_op(8'hD0, 2'h2, 3'h2, CDT_POP);
	endtask : t_ext

	// exchanges over all register and pointer selects
	task t_xch;
		for (int i = 0; i < 8; i++) begin
			check_op(8'hC8 | 8'(i), 2'h1, 3'h1, CDT_XCH);
			`CHK(dec_out.reg_sel, 3'(i))
		end
		check_op(8'hC5, 2'h2, 3'h1, CDT_XCH);
		check_op(8'hC6, 2'h1, 3'h1, CDT_XCH);
		`CHK(dec_out.ptr_sel, 1'b0)
		check_op(8'hC7, 2'h1, 3'h1, CDT_XCH);
		check_op(8'hD6, 2'h1, 3'h1, CDT_NIB_XCH);
		check_op(8'hD7, 2'h1, 3'h1, CDT_NIB_XCH);
	endtask : t_xch

	// carry logic and bit moves
	task t_bool;
		check_op(8'h82, 2'h2, 3'h2, CDT_BIT_LOGIC);
		`CHK({dec_out.invert, dec_out.cond_sense}, 2'b00)
		check_op(8'hB0, 2'h2, 3'h2, CDT_BIT_LOGIC);
		`CHK({dec_out.invert, dec_out.cond_sense}, 2'b10)
		check_op(8'h72, 2'h2, 3'h2, CDT_BIT_LOGIC);
		`CHK({dec_out.invert, dec_out.cond_sense}, 2'b01)
		check_op(8'hA0, 2'h2, 3'h2, CDT_BIT_LOGIC);
		`CHK({dec_out.invert, dec_out.cond_sense}, 2'b11)
		check_op(8'hA2, 2'h2, 3'h1, CDT_BIT_MOVE);
		check_op(8'h92, 2'h2, 3'h2, CDT_BIT_MOVE);
	endtask : t_bool

	// calls, jumps and branches
	task t_branch;
		check_op(8'h12, 2'h3, 3'h2, CDT_CALL);
		`CHK(pc_out.far_form, 1'b1)
		check_op(8'h80, 2'h2, 3'h2, CDT_JUMP);
		`CHK(pc_out.rel_form, 1'b1)
		check_op(8'h20, 2'h3, 3'h2, CDT_COND_BRANCH);
		check_op(8'h30, 2'h3, 3'h2, CDT_COND_BRANCH);
		check_op(8'h10, 2'h3, 3'h2, CDT_BTC_BRANCH);
		check_op(8'h73, 2'h1, 3'h2, CDT_JUMP);
		`CHK(pc_out.acc_dp_form, 1'b1)
		check_op(8'h60, 2'h2, 3'h2, CDT_COND_BRANCH);
		check_op(8'h70, 2'h2, 3'h2, CDT_COND_BRANCH);
		for (int i = 4; i < 16; i++) begin
			check_op(8'hB0 | 8'(i), 2'h3, 3'h2, CDT_CBU);
		end
		for (int i = 0; i < 8; i++) begin
			check_op(8'hD8 | 8'(i), 2'h2, 3'h2, CDT_DBN);
		end
		check_op(8'hD5, 2'h3, 3'h2, CDT_DBN);
	endtask : t_branch

	// carry and bit set/clear, returns, far jump, carry branches, no-op, opcode outside this part
	task t_misc;
		check_op(8'hC3, 2'h1, 3'h1, CDT_BIT_SET_CLR);
		check_op(8'hC2, 2'h2, 3'h1, CDT_BIT_SET_CLR);
		check_op(8'hD3, 2'h1, 3'h1, CDT_BIT_SET_CLR);
		check_op(8'hD2, 2'h2, 3'h1, CDT_BIT_SET_CLR);
		check_op(8'hB3, 2'h1, 3'h1, CDT_BIT_SET_CLR);
		check_op(8'hB2, 2'h2, 3'h1, CDT_BIT_SET_CLR);
		check_op(8'h22, 2'h1, 3'h2, CDT_RETURN);
		check_op(8'h32, 2'h1, 3'h2, CDT_RETURN);
		check_op(8'h02, 2'h3, 3'h2, CDT_JUMP);
		`CHK(pc_out.far_form, 1'b1)
		check_op(8'h40, 2'h2, 3'h2, CDT_COND_BRANCH);
		check_op(8'h50, 2'h2, 3'h2, CDT_COND_BRANCH);
		check_op(8'h00, 2'h1, 3'h1, CDT_NONE);
		`CHK(dec_out.iclass, CDT_NONE)
		opcode_in = 8'h28;
		@(negedge core_clk);
		`CHK(dec_out.known, 1'b0)
		`CHK(dec_out.iclass, CDT_NONE)
		`CHK(dec_out.length, LEN_1)
		`CHK(dec_out.cycles, CYC_1)
	endtask : t_misc

	// page call target at pc FFFF, page jump target at pc 0800
	task t_page;
		addr_low = 8'h5A;
		pc_next = 16'hFFFF;
		opcode_in = 8'hB1;
		@(negedge core_clk);
		`CHK(pc_out.page_form, 1'b1)
		`CHK(pc_out.page_target, 16'hFD5A)
		`CHK(dec_out.iclass, CDT_CALL)
		pc_next = 16'h0800;
		opcode_in = 8'h61;
		@(negedge core_clk);
		`CHK(pc_out.page_target, 16'h0B5A)
		`CHK(pc_out.page_form, 1'b1)
		`CHK(dec_out.iclass, CDT_JUMP)
	endtask : t_page

	// reset in mid-run clears outputs, decode resumes without valid
	task t_reset_mid;
		rst = 1'b1;
		opcode_valid = 1'b0;
		@(negedge core_clk);
		`CHK(dec_out, cdt_dec_t'(0))
		`CHK(pc_out, cdt_pc_t'(0))
		rst = 1'b0;
		opcode_in = 8'h12;
		@(negedge core_clk);
		`CHK(dec_out.length, LEN_3)
		`CHK(dec_valid, 1'b0)
	endtask : t_reset_mid

	// counts and verdict, then stop
	task final_report;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : final_report

	// main sequence
	initial begin
		num_errors = 0;
		comparisons = 0;
		opcode_in = 8'h00;
		opcode_valid = 1'b0;
		addr_low = 8'h00;
		pc_next = 16'h0000;
		repeat (12) @(negedge core_clk);
		rst = 1'b0;
		t_moves();
		t_ext();
		t_xch();
		t_bool();
		t_branch();
		t_misc();
		t_page();
		t_reset_mid();
		final_report();
	end

	// watchdog well beyond the 95 cycles needed
	initial begin
		#20000;
		num_errors++;
		final_report();
	end
endmodule : tb_top
